// *** verilog/prs_dev.sv ***
// pressure readout slave: conversion cycle and two-wire read port
`timescale 1ns/100ps
`include "prs_defs.svh"

module prs_dev #(
  parameter int unsigned CONV_CYCLES = `PRS_CONV_NS / `PRS_CLK_NS,
  parameter bit          SEC_EN      = 1'b0,
  parameter logic [6:0]  SEC_ADDR    = 7'h28
) (
  input  logic        ref_clk_in,
  input  logic        sys_rst_in,
  input  logic [11:0] pressure_code_in,
  output logic [14:0] value_out,
  output logic        sample_tick_out,
  output logic        bus_idle_out,
  prs_if.slave        bus
);

  // ref clock domain
  logic [15:0] conv_cnt_q;
  logic        conv_due_q;
  logic [14:0] value_q;
  logic        tick_q;
  logic        scl_m_q;
  logic        scl_s_q;
  logic        sda_m_q;
  logic        sda_s_q;
  logic        sda_p_q;
  logic        idle_q;
  logic        conv_wrap;
  logic        conv_load;
  logic        start_seen;
  logic        stop_seen;

  // link (scl) domain
  logic                 link_rst;
  logic                 hi_q;
  logic [7:0]           rx_q;
  logic [7:0]           sh_q;
  logic [2:0]           cnt_q;
  logic                 byte_q;
  logic                 rw_q;
  logic                 pull_q;
  logic [7:0]           tx_hi;
  logic [7:0]           tx_lo;
  prs_pkg::prs_dev_st_t st_q;

  function automatic logic [14:0] prs_scale(input logic [11:0] code);
    logic [26:0] prod;
    prod = 27'(code) * 27'(`PRS_FULL_SPAN);
    prs_scale = `PRS_ZERO_UNI + 15'(prod >> `PRS_CODE_BITS);
  endfunction : prs_scale

  function automatic logic addr_hit(input logic [6:0] a);
    addr_hit = (a == `PRS_ADDR_DEF) || (SEC_EN && (a == SEC_ADDR));
  endfunction : addr_hit

  // upper byte carries a zero msb above the 15-bit value
  function automatic logic [7:0] tx_byte(input logic second, input logic [14:0] v);
    logic [15:0] w;
    w = {1'b0, v};
    tx_byte = second ? w[7:0] : w[15:8];
  endfunction : tx_byte

  // ---------------- conversion cycle ----------------

  assign conv_wrap = (conv_cnt_q == 16'(CONV_CYCLES - 1));
  assign conv_load = conv_due_q && idle_q;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      conv_cnt_q <= '0;
    end else if (conv_wrap) begin
      conv_cnt_q <= '0;
    end else begin
      conv_cnt_q <= conv_cnt_q + 16'h0001;
    end
  end

  // a refresh falling due during a frame waits for the bus to go idle
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      conv_due_q <= 1'b0;
    end else begin
      conv_due_q <= conv_wrap | (conv_due_q & ~conv_load);
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      value_q <= `PRS_ZERO_UNI;
      tick_q  <= 1'b0;
    end else begin
      tick_q <= conv_load;
      if (conv_load) begin
        value_q <= prs_scale(pressure_code_in);
      end
    end
  end

  // ---------------- bus state seen from the ref clock ----------------

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= bus.scl;
      scl_s_q <= scl_m_q;
      sda_m_q <= bus.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign start_seen = scl_s_q && sda_p_q && !sda_s_q;
  assign stop_seen  = scl_s_q && !sda_p_q && sda_s_q;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idle_q <= 1'b1;
    end else if (start_seen) begin
      idle_q <= 1'b0;
    end else if (stop_seen) begin
      idle_q <= 1'b1;
    end
  end

  assign value_out       = value_q;
  assign sample_tick_out = tick_q;
  assign bus_idle_out    = idle_q;

  // ---------------- link side, clocked by scl ----------------

  // scl stands still after a stop, so the ref side holds the link logic
  // in reset until the next start; value_q is only refreshed meanwhile
  assign link_rst = sys_rst_in | idle_q;

  // value_q is frozen while a frame runs, so the scl side may read these
  assign tx_hi = tx_byte(1'b0, value_q);
  assign tx_lo = tx_byte(1'b1, value_q);

  always_ff @(posedge bus.scl or posedge link_rst) begin
    if (link_rst) begin
      hi_q <= 1'b1;
      rx_q <= '0;
    end else begin
      hi_q <= bus.sda;
      rx_q <= {rx_q[6:0], bus.sda};
    end
  end

  // sda falling between the rising and falling clock edge is a start
  always_ff @(negedge bus.scl or posedge link_rst) begin
    if (link_rst) begin
      st_q   <= prs_pkg::D_IDLE;
      cnt_q  <= '0;
      sh_q   <= '0;
      byte_q <= 1'b0;
      rw_q   <= 1'b0;
      pull_q <= 1'b0;
    end else if (hi_q && !bus.sda) begin
      st_q   <= prs_pkg::D_ADDR;
      cnt_q  <= '0;
      byte_q <= 1'b0;
      pull_q <= 1'b0;
    end else begin
      case (st_q)
        prs_pkg::D_ADDR: begin
          if (cnt_q == `PRS_LAST_BIT) begin
            if (addr_hit(rx_q[7:1])) begin
              st_q   <= prs_pkg::D_AACK;
              rw_q   <= rx_q[0];
              pull_q <= 1'b1;
            end else begin
              st_q <= prs_pkg::D_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        prs_pkg::D_AACK: begin
          cnt_q <= '0;
          if (rw_q == `PRS_DIR_RD) begin
            st_q   <= prs_pkg::D_TX;
            sh_q   <= tx_hi;
            pull_q <= ~tx_hi[7];
          end else begin
            st_q   <= prs_pkg::D_WRX;
            pull_q <= 1'b0;
          end
        end
        prs_pkg::D_TX: begin
          if (cnt_q == `PRS_LAST_BIT) begin
            st_q   <= prs_pkg::D_RACK;
            pull_q <= 1'b0;
          end else begin
            cnt_q  <= cnt_q + 3'h1;
            sh_q   <= {sh_q[6:0], 1'b0};
            pull_q <= ~sh_q[6];
          end
        end
        prs_pkg::D_RACK: begin
          cnt_q <= '0;
          if (!hi_q && !byte_q) begin
            st_q   <= prs_pkg::D_TX;
            byte_q <= 1'b1;
            sh_q   <= tx_lo;
            pull_q <= ~tx_lo[7];
          end else begin
            st_q   <= prs_pkg::D_IDLE;
            pull_q <= 1'b0;
          end
        end
        prs_pkg::D_WRX: begin
          if (cnt_q == `PRS_LAST_BIT) begin
            st_q   <= prs_pkg::D_WACK;
            pull_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        prs_pkg::D_WACK: begin
          // written bytes are acknowledged and dropped: nothing is writable
          st_q   <= prs_pkg::D_WRX;
          cnt_q  <= '0;
          pull_q <= 1'b0;
        end
        prs_pkg::D_IDLE: begin
          pull_q <= 1'b0;
        end
        default: begin
          st_q   <= prs_pkg::D_IDLE;
          pull_q <= 1'b0;
        end
      endcase
    end
  end

  // never drives scl: only answers the master's clock
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = ~pull_q;

endmodule : prs_dev

// *** inc/prs_defs.svh ***
// constants shared by both ends of the pressure readout link
//
// Summary of operation
// - refresh 12-bit corrected sample every 250 us
// - device only answers, never initiates traffic
// - idle bus: nobody pulls either line
// - start: data falls while clock high
// - stop: data rises while clock high
// - repeated start begins a fresh request
// - data changes only while clock low
// - bytes of eight bits, msb first
// - receiver acknowledges each byte on ninth pulse; the host leaves the last read byte unacknowledged
// - missed acknowledge: device stops, releases data
// - master then repeats command or stops
// - default address 1111000 plus direction bit
// - optional second address answered as well
// - address byte: address then read/write bit
// - read returns two bytes, 15-bit value
// - bidirectional: 3000 min, 16500 zero, 30000 max
// - master clock 100 to 400 kHz
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

`define PRS_CLK_NS     25
`define PRS_CONV_NS    250000
`define PRS_SCL_NS     4000
`define PRS_SCL_PHASES 4
`define PRS_QTR_CYC    ((`PRS_SCL_NS / `PRS_SCL_PHASES) / `PRS_CLK_NS)

`define PRS_ADDR_DEF   7'h78
`define PRS_DIR_RD     1'b1
`define PRS_CODE_BITS  12
`define PRS_ZERO_UNI   15'h0bb8
`define PRS_ZERO_BI    15'h4074
`define PRS_FULL_OUT   15'h7530
`define PRS_FULL_SPAN  15'h6978

`define PRS_LAST_BIT   3'h7
`define PRS_ACK_POS    4'h8
`define PRS_LAST_BYTE  2'h2

`define PRS_PH_SET     2'h0
`define PRS_PH_RISE    2'h1
`define PRS_PH_SMP     2'h2
`define PRS_PH_FALL    2'h3

`endif

// *** inc/prs_pkg.sv ***
// state types of both ends of the pressure readout link
package prs_pkg;

  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_AACK,
    D_TX,
    D_RACK,
    D_WRX,
    D_WACK
  } prs_dev_st_t;

  typedef enum logic [1:0] {
    H_IDLE,
    H_START,
    H_BITS,
    H_STOP
  } prs_host_st_t;

endpackage : prs_pkg

// *** inc/prs_if.sv ***
// two-wire link between master and pressure readout slave
`timescale 1ns/100ps
interface prs_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups: a line is low only while someone pulls it
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport master (
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n,
    input  scl,
    input  sda
  );

  modport slave (
    output dev_sda_o,
    output dev_sda_oe_n,
    input  scl,
    input  sda
  );
endinterface : prs_if

// *** verilog/prs_host.sv ***
// two-wire master that reads the pressure value from the slave
`timescale 1ns/100ps
`include "prs_defs.svh"

module prs_host (
  input  logic        ref_clk_in,
  input  logic        sys_rst_in,
  input  logic        rd_req_in,
  input  logic [6:0]  addr_in,
  output logic        busy_out,
  output logic        done_out,
  output logic        nack_out,
  output logic [14:0] value_out,
  prs_if.master       bus
);

  logic [5:0]            qcnt_q;
  logic                  tick;
  logic [1:0]            ph_q;
  logic [3:0]            pos_q;
  logic [1:0]            byte_q;
  logic [7:0]            tx_q;
  logic [15:0]           rx_q;
  logic                  pend_q;
  logic                  scl_low_q;
  logic                  sda_low_q;
  logic                  sda_m_q;
  logic                  sda_s_q;
  logic                  nack_q;
  logic                  done_q;
  logic [14:0]           value_q;
  prs_pkg::prs_host_st_t st_q;

  // quarter-period tick: one scl period is four quarters of 40 ref cycles
  assign tick = (qcnt_q == 6'(`PRS_QTR_CYC - 1));

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      qcnt_q <= '0;
    end else if (tick) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= qcnt_q + 6'h01;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= bus.sda;
      sda_s_q <= sda_m_q;
    end
  end

  // a request while busy is dropped; one arriving as the frame opens is kept
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= (rd_req_in && st_q == prs_pkg::H_IDLE) ||
                (pend_q && !(tick && st_q == prs_pkg::H_IDLE));
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q      <= prs_pkg::H_IDLE;
      ph_q      <= `PRS_PH_SET;
      pos_q     <= '0;
      byte_q    <= '0;
      tx_q      <= '0;
      rx_q      <= '0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      nack_q    <= 1'b0;
      done_q    <= 1'b0;
      value_q   <= '0;
    end else begin
      done_q <= 1'b0;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (st_q)
          prs_pkg::H_IDLE: begin
            ph_q <= `PRS_PH_SET;
            if (pend_q) begin
              st_q   <= prs_pkg::H_START;
              tx_q   <= {addr_in, `PRS_DIR_RD};
              pos_q  <= '0;
              byte_q <= '0;
              nack_q <= 1'b0;
            end
          end
          prs_pkg::H_START: begin
            if (ph_q == `PRS_PH_SET) begin
              sda_low_q <= 1'b1;
            end else begin
              scl_low_q <= 1'b1;
              st_q      <= prs_pkg::H_BITS;
              ph_q      <= `PRS_PH_SET;
            end
          end
          prs_pkg::H_BITS: begin
            case (ph_q)
              `PRS_PH_SET: begin
                if (pos_q == `PRS_ACK_POS) begin
                  sda_low_q <= (byte_q != 2'h0) && (byte_q != `PRS_LAST_BYTE);
                end else begin
                  sda_low_q <= (byte_q == 2'h0) && !tx_q[7];
                end
              end
              `PRS_PH_RISE: begin
                scl_low_q <= 1'b0;
              end
              `PRS_PH_SMP: begin
                if (pos_q == `PRS_ACK_POS) begin
                  nack_q <= (byte_q == 2'h0) && sda_s_q;
                end else if (byte_q != 2'h0) begin
                  rx_q <= {rx_q[14:0], sda_s_q};
                end
              end
              default: begin
                scl_low_q <= 1'b1;
                if (pos_q == `PRS_ACK_POS) begin
                  pos_q <= '0;
                  if (nack_q || byte_q == `PRS_LAST_BYTE) begin
                    st_q <= prs_pkg::H_STOP;
                  end else begin
                    byte_q <= byte_q + 2'h1;
                  end
                end else begin
                  pos_q <= pos_q + 4'h1;
                  tx_q  <= {tx_q[6:0], 1'b0};
                end
              end
            endcase
          end
          prs_pkg::H_STOP: begin
            case (ph_q)
              `PRS_PH_SET: begin
                sda_low_q <= 1'b1;
              end
              `PRS_PH_RISE: begin
                scl_low_q <= 1'b0;
              end
              `PRS_PH_SMP: begin
                sda_low_q <= 1'b0;
              end
              default: begin
                st_q   <= prs_pkg::H_IDLE;
                done_q <= 1'b1;
                if (!nack_q) begin
                  value_q <= rx_q[14:0];
                end
              end
            endcase
          end
          default: begin
            st_q <= prs_pkg::H_IDLE;
          end
        endcase
      end
    end
  end

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_scl_oe_n = ~scl_low_q;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = ~sda_low_q;
  assign busy_out          = (st_q != prs_pkg::H_IDLE);
  assign done_out          = done_q;
  assign nack_out          = nack_q;
  assign value_out         = value_q;

endmodule : prs_host

// *** dv/prs_link_sva.sv ***
// concurrent checks on the two-wire link between master and slave
`timescale 1ns/100ps
module prs_link_sva (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic host_scl_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  logic [4:0] cnt_q;
  logic [7:0] shift_q;
  logic       idle_q;

  // scl rises since the last start; the stop's own rise is counted too
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q <= 5'h00;
    end else if ($fell(sda) && scl) begin
      cnt_q <= 5'h00;
    end else if ($rose(scl)) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_q <= 8'h00;
    end else if ($rose(scl)) begin
      shift_q <= {shift_q[6:0], sda};
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      idle_q <= 1'b1;
    end else if ($rose(sda) && scl) begin
      idle_q <= 1'b1;
    end else if ($fell(sda) && scl) begin
      idle_q <= 1'b0;
    end
  end

  a_idle_released: assert property (idle_q |-> host_scl_oe_n && dev_sda_oe_n)
    else $error("line pulled while bus idle");
  a_start_hold: assert property ($fell(sda) && scl |-> scl [*8])
    else $error("clock dropped right after start");
  a_stop_idle: assert property ($rose(sda) && scl |=> (sda && scl) [*8])
    else $error("bus not idle after stop");
  a_frame_pulses: assert property ($rose(sda) && scl |-> cnt_q == 5'h1c || cnt_q == 5'h0a)
    else $error("wrong clock pulse count in frame");
  a_dev_stable: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("slave changed data while clock high");
  a_addr_ack: assert property ($rose(scl) && cnt_q == 5'h08 |-> sda == (shift_q[7:1] != 7'h78))
    else $error("address acknowledge wrong");
  a_data_msb: assert property ($rose(scl) && cnt_q == 5'h09 && shift_q[0] == 1'b0 |-> !sda)
    else $error("top bit of value not zero");
  a_host_ack: assert property ($rose(scl) && cnt_q == 5'h11 |-> !sda)
    else $error("first data byte not acknowledged");
  a_host_nack_last: assert property ($rose(scl) && cnt_q == 5'h1a |-> sda && dev_sda_oe_n)
    else $error("slave still driving after last byte");

  c_read_frame: cover property ($rose(sda) && scl && cnt_q == 5'h1c);
  c_nack_frame: cover property ($rose(sda) && scl && cnt_q == 5'h0a);
  c_addr_acked: cover property ($rose(scl) && cnt_q == 5'h08 && !sda);
endmodule : prs_link_sva

// *** dv/prs_readout_tb.sv ***
// self-checking bench: master and slave joined over the two-wire link
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module prs_readout_tb;
  logic        ref_clk_in;
  logic        sys_rst_in;
  logic [11:0] pressure_code_in;
  logic        rd_req_in;
  logic [6:0]  addr_in;
  logic [14:0] dev_value;
  logic        sample_tick;
  logic        bus_idle;
  logic        busy_out;
  logic        done_out;
  logic        nack_out;
  logic [14:0] host_value;
  logic [15:0] exp_q[$];
  logic [15:0] exp_note;
  logic [14:0] last_val;
  int          miscompares;
  int          check_count;
  int          seed;
  int          i;

  prs_if bus_if ();
  prs_dev #(.CONV_CYCLES(50)) u_prs_dev (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .pressure_code_in(pressure_code_in), .value_out(dev_value), .sample_tick_out(sample_tick),
    .bus_idle_out(bus_idle), .bus(bus_if));
  prs_host u_prs_host (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .rd_req_in(rd_req_in),
    .addr_in(addr_in), .busy_out(busy_out), .done_out(done_out), .nack_out(nack_out),
    .value_out(host_value), .bus(bus_if));
  prs_link_sva u_prs_link_sva (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .host_scl_oe_n(bus_if.host_scl_oe_n), .dev_sda_oe_n(bus_if.dev_sda_oe_n),
    .scl(bus_if.scl), .sda(bus_if.sda));

  initial ref_clk_in = 1'b0;
  always #12.5 ref_clk_in = ~ref_clk_in;

  task complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // value only settles on a refresh after the new code, so wait for a tick past cycle 60
  task set_code(input logic [11:0] c);
    int n;
    pressure_code_in <= c;
    for (n = 0; n < 400; n++) begin
      @(posedge ref_clk_in);
      if (sample_tick === 1'b1 && n > 60) break;
    end
    last_val = 15'(32'h0bb8 + ((32'(c) * 32'h6978) >> 12));
    `CHK("slave value", last_val, dev_value)
  endtask : set_code

  task do_read(input logic [6:0] a, input logic [15:0] exp);
    int n;
    exp_q.push_back(exp);
    @(posedge ref_clk_in);
    rd_req_in <= 1'b1;
    addr_in   <= a;
    @(posedge ref_clk_in);
    rd_req_in <= 1'b0;
    // the frame opens at the next quarter tick, at most 40 cycles on
    repeat (45) @(posedge ref_clk_in);
    `CHK("busy in frame", 1'b1, busy_out)
    for (n = 0; n < 6000 && done_out !== 1'b1; n++) @(posedge ref_clk_in);
    if (n == 6000) begin
      miscompares++;
      $display("[ERR] read done expected 1 seen 0");
    end
    @(posedge ref_clk_in);
  endtask : do_read

  // results are compared at the done pulse, in the order they were asked
  always @(posedge ref_clk_in) begin
    if (done_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("[ERR] unexpected done expected none seen 1");
      end else begin
        exp_note = exp_q.pop_front();
        `CHK("nack", exp_note[15], nack_out)
        `CHK("read value", exp_note[14:0], host_value)
        `CHK("busy at done", 1'b0, busy_out)
      end
    end
  end

  initial begin
    repeat (90000) @(posedge ref_clk_in);
    miscompares++;
    $display("[ERR] run time expected done seen hang");
    complete_run();
  end

  initial begin
    seed = 32'h48d0;
    miscompares = 0;
    check_count = 0;
    sys_rst_in = 1'b1;
    pressure_code_in = 12'h000;
    rd_req_in = 1'b0;
    addr_in = 7'h78;
    repeat (8) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    `CHK("reset value", 15'h0bb8, dev_value)
    `CHK("idle lines", 2'h3, {bus_if.scl, bus_if.sda})
    `CHK("idle flag", 1'b1, bus_idle)
    `CHK("host reset", 18'h00000, {busy_out, done_out, nack_out, host_value})
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      case (i)
        0: set_code(12'h000);
        1: set_code(12'h800);
        2: set_code(12'hfff);
        default: set_code(12'($random(seed)));
      endcase
      do_read(7'h78, {1'b0, last_val});
    end
    $display("test code sweep done");
    // host keeps its last good value when the address is refused
    do_read(7'h79, {1'b1, last_val});
    // second address is off in this build, so it must be refused
    do_read(7'h28, {1'b1, last_val});
    do_read(7'h78 ^ (7'h01 + 7'($random(seed) & 7'h3e)), {1'b1, last_val});
    $display("test wrong address done");
    do_read(7'h78, {1'b0, last_val});
    do_read(7'h78, {1'b0, last_val});
    $display("test back to back done");
    repeat (10) @(posedge ref_clk_in);
    `CHK("pending results", 0, exp_q.size())
    complete_run();
  end
endmodule : prs_readout_tb
